// ---- verilog/asram_pkg.sv ----
// Constants and helpers for the host-side controller of a 1K x 4 async SRAM.
// Assumes a 200 MHz controller clock; access, float, select-low and data-setup timings are turned into cycles.
package asram_pkg;

  // Organisation
  localparam int ADDR_W = 10;
  localparam int DATA_W = 4;

  // Controller clock period
  localparam int T_CLK_NS = 5;

  // Pin timings in ns, as printed for the fastest grade, float for the slowest
  localparam int T_ACCESS_NS = 25; // Select or address to valid data
  localparam int T_FLOAT_NS = 20; // Strobe to data float, slowest grade covers all
  localparam int T_SEL_LOW_NS = 20; // Select low to end of write
  localparam int T_STROBE_NS = 15; // Write strobe pulse width
  localparam int T_WCYCLE_NS = 20; // Whole write cycle
  localparam int T_ADDR_SETUP_NS = 20; // Address stable to end of write
  localparam int T_DSETUP_NS = 10; // Data setup to select rising

  // Synchroniser depth on the returning data lines
  localparam int SYNC_STAGES = 2;

  // Counter width for timing states
  localparam int CNT_W = 8;

  // Pin reset levels
  localparam logic PIN_IDLE_N = 1'b1;

  // Least time to whole cycles, never below one
  function automatic int cyc_min(input int t_ns);
    int c;
    c = (t_ns + T_CLK_NS - 1) / T_CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction : cyc_min

  // Larger of two counts
  function automatic int max2(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : max2

endpackage : asram_pkg

// ---- verilog/asram_pin_if.sv ----
// Carries the returning data lines between the controller and its synchroniser.
// Assumes raw pin data is asynchronous to the controller clock.
`timescale 1ns/100ps
interface asram_pin_if;
  logic [asram_pkg::DATA_W-1:0] data_raw;
  logic [asram_pkg::DATA_W-1:0] data_sync;

  modport ctrl (output data_raw, input data_sync);
  modport sync (input data_raw, output data_sync);
endinterface : asram_pin_if

// ---- verilog/asram_sync.sv ----
// Two-stage synchroniser for the SRAM data lines.
// Assumes the controller only reads the output once the pins have settled.
`timescale 1ns/100ps
module asram_sync (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Pin data in, synchronised data out
  asram_pin_if.sync pins
);

  logic [asram_pkg::DATA_W-1:0] meta_q;
  logic [asram_pkg::DATA_W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins.data_raw;
      sync_q <= meta_q;
    end
  end

  assign pins.data_sync = sync_q;

endmodule : asram_sync

// ---- verilog/asram_ctrl.sv ----
// Host controller that drives a 1K x 4 asynchronous SRAM through its pins.
// Assumes a single 200 MHz clock and a user that waits for O_READY.
// Operation
// - Drive write data only after float delay
// - Select or strobe high during address change
// - Control pins change cleanly and monotonically
// - Select low 20, strobe 15, cycle 20
// - Address stable 20 ns before write end
// - Shared data lines, one driver at once
`timescale 1ns/100ps
module asram_ctrl #(
  parameter int T_ACCESS_NS = asram_pkg::T_ACCESS_NS,
  parameter int T_FLOAT_NS = asram_pkg::T_FLOAT_NS,
  parameter int T_SEL_LOW_NS = asram_pkg::T_SEL_LOW_NS,
  parameter int T_DSETUP_NS = asram_pkg::T_DSETUP_NS
) (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // User request
  input wire logic I_REQ,
  input wire logic I_WE,
  input wire logic [asram_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [asram_pkg::DATA_W-1:0] I_WDATA,
  // User answer
  output logic O_READY,
  output logic O_RVALID,
  output logic [asram_pkg::DATA_W-1:0] O_RDATA,
  // Memory pins
  output logic O_CSN,
  output logic O_STROBE_N,
  output logic [asram_pkg::ADDR_W-1:0] O_ADDR,
  output logic [asram_pkg::DATA_W-1:0] O_DATA,
  output logic O_DATA_OE,
  input wire logic [asram_pkg::DATA_W-1:0] I_DATA
);

  // Cycle counts from pin timings
  localparam int ACC_CYC = asram_pkg::cyc_min(T_ACCESS_NS);
  localparam int FLOAT_CYC = asram_pkg::cyc_min(T_FLOAT_NS);
  localparam int SEL_CYC = asram_pkg::cyc_min(T_SEL_LOW_NS);
  localparam int DSET_CYC = asram_pkg::cyc_min(T_DSETUP_NS);
  // Data phase must cover data setup and the rest of the select-low time
  localparam int WDATA_CYC = asram_pkg::max2(DSET_CYC, SEL_CYC - FLOAT_CYC);
  localparam int CNT_W = asram_pkg::CNT_W;
  localparam logic [CNT_W-1:0] ACC_LOAD = CNT_W'(ACC_CYC - 1);
  localparam logic [CNT_W-1:0] FLOAT_LOAD = CNT_W'(FLOAT_CYC - 1);
  localparam logic [CNT_W-1:0] WDATA_LOAD = CNT_W'(WDATA_CYC - 1);
  // One spare cycle past the stages, so the first stage never samples on the
  // very edge at which the access time ends and the data may still be moving
  localparam logic [CNT_W-1:0] SYNC_LOAD = CNT_W'(asram_pkg::SYNC_STAGES);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DESEL,
    ST_RD_ACCESS,
    ST_RD_SYNC,
    ST_WR_STROBE,
    ST_WR_SELECT,
    ST_WR_FLOAT,
    ST_WR_DATA,
    ST_WR_END,
    ST_RECOVER
  } asram_state_t;

  asram_state_t state_q;
  asram_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [asram_pkg::ADDR_W-1:0] req_addr_q;
  logic [asram_pkg::DATA_W-1:0] req_data_q;
  logic accept;
  logic last;
  logic csn_q;
  logic strobe_n_q;
  logic [asram_pkg::ADDR_W-1:0] addr_q;
  logic [asram_pkg::DATA_W-1:0] data_q;
  logic data_oe_q;
  logic ready_q;
  logic rvalid_q;
  logic [asram_pkg::DATA_W-1:0] rdata_q;

  asram_pin_if pin_if ();

  // Returning data is asynchronous, so it is resynchronised first
  assign pin_if.data_raw = I_DATA;

  asram_sync u_sync (
    .i_clk (I_MCLK),
    .i_reset (I_RESET),
    .pins (pin_if.sync)
  );

  assign accept = ready_q & I_REQ;
  assign last = (cnt_q == '0);

  // Next state and timing counter
  always_comb begin
    state_d = state_q;
    cnt_d = last ? cnt_q : cnt_q - 1'b1;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          if (I_WE && !csn_q) begin
            state_d = ST_DESEL;
          end else if (I_WE) begin
            state_d = ST_WR_STROBE;
          end else begin
            state_d = ST_RD_ACCESS;
            cnt_d = ACC_LOAD;
          end
        end
      end
      ST_DESEL: begin
        state_d = ST_WR_STROBE;
      end
      ST_RD_ACCESS: begin
        if (last) begin
          state_d = ST_RD_SYNC;
          cnt_d = SYNC_LOAD;
        end
      end
      ST_RD_SYNC: begin
        if (last) begin
          state_d = ST_IDLE;
        end
      end
      ST_WR_STROBE: begin
        state_d = ST_WR_SELECT;
      end
      ST_WR_SELECT: begin
        state_d = ST_WR_FLOAT;
        cnt_d = FLOAT_LOAD;
      end
      ST_WR_FLOAT: begin
        if (last) begin
          state_d = ST_WR_DATA;
          cnt_d = WDATA_LOAD;
        end
      end
      ST_WR_DATA: begin
        if (last) begin
          state_d = ST_WR_END;
        end
      end
      ST_WR_END: begin
        state_d = ST_RECOVER;
      end
      ST_RECOVER: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State and counter registers
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Request capture, held until the pins take it
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      req_addr_q <= '0;
      req_data_q <= '0;
    end else if (accept) begin
      req_addr_q <= I_ADDR;
      req_data_q <= I_WDATA;
    end
  end

  // Select pin; every change is a single registered step
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      csn_q <= asram_pkg::PIN_IDLE_N;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (accept && !I_WE) begin
            csn_q <= 1'b0;
          end else if (accept || !csn_q) begin
            csn_q <= 1'b1;
          end
        end
        ST_WR_SELECT: begin
          csn_q <= 1'b0;
        end
        ST_WR_DATA: begin
          if (last) begin
            csn_q <= 1'b1;
          end
        end
        default: begin
          csn_q <= csn_q;
        end
      endcase
    end
  end

  // Write strobe pin, falls before select so the memory never drives
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      strobe_n_q <= asram_pkg::PIN_IDLE_N;
    end else if (state_q == ST_WR_STROBE) begin
      strobe_n_q <= 1'b0;
    end else if (state_q == ST_WR_END) begin
      strobe_n_q <= 1'b1;
    end
  end

  // Address pins only move while a control pin is high or for reads
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      addr_q <= '0;
    end else if (state_q == ST_IDLE && accept && !I_WE) begin
      addr_q <= I_ADDR;
    end else if (state_q == ST_WR_STROBE && strobe_n_q) begin
      addr_q <= req_addr_q;
    end
  end

  // Data drive: only inside the write, after the memory has floated
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      data_q <= '0;
      data_oe_q <= 1'b0;
    end else if (state_q == ST_WR_FLOAT && last) begin
      data_q <= req_data_q;
      data_oe_q <= 1'b1;
    end else if (state_q == ST_WR_END) begin
      data_oe_q <= 1'b0;
    end
  end

  // Ready for one request when the machine returns to idle
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == ST_IDLE);
    end
  end

  // Read data taken from the synchronised lines after the access time
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rvalid_q <= 1'b0;
      if (state_q == ST_RD_SYNC && last) begin
        rvalid_q <= 1'b1;
        rdata_q <= pin_if.data_sync;
      end
    end
  end

  // Every output straight from a register
  assign O_READY = ready_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_CSN = csn_q;
  assign O_STROBE_N = strobe_n_q;
  assign O_ADDR = addr_q;
  assign O_DATA = data_q;
  assign O_DATA_OE = data_oe_q;

endmodule : asram_ctrl

// ---- sim/asram_ctrl_chk.sv ----
// Pin-timing checks for the SRAM controller.
// Assumes it is bound to asram_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module asram_ctrl_chk (
  // Clock, reset and user side
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_REQ,
  input wire logic I_WE,
  input wire logic O_READY,
  input wire logic O_RVALID,
  // Memory pins
  input wire logic O_CSN,
  input wire logic O_STROBE_N,
  input wire logic [asram_pkg::ADDR_W-1:0] O_ADDR,
  input wire logic O_DATA_OE
);
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RESET);

  // Pin relations, one cycle is 5 ns
  property p_float; $rose(O_DATA_OE) |-> !O_STROBE_N && !$past(O_STROBE_N, 4); endproperty
  property p_amove; !$stable(O_ADDR) |-> (O_CSN || O_STROBE_N) && ($past(O_CSN) || $past(O_STROBE_N)); endproperty
  property p_sel; $rose(O_CSN) && !O_STROBE_N |-> !$past(O_CSN, 1) && !$past(O_CSN, 4); endproperty
  property p_pulse; $rose(O_STROBE_N) |-> !$past(O_STROBE_N, 3); endproperty
  property p_asetup; $rose(O_CSN) && !O_STROBE_N |-> $past(O_ADDR, 4) == O_ADDR; endproperty
  property p_oe; O_DATA_OE |-> !O_STROBE_N; endproperty
  property p_clean; $fell(O_CSN) |=> !O_CSN; endproperty
  property p_rlat; I_REQ && O_READY && !I_WE |-> ##9 O_RVALID; endproperty
  a_float: assert property (p_float) else $error("data before float");
  a_amove: assert property (p_amove) else $error("address moved in write");
  a_sel: assert property (p_sel) else $error("select low too short");
  a_pulse: assert property (p_pulse) else $error("strobe too short");
  a_asetup: assert property (p_asetup) else $error("address setup");
  a_oe: assert property (p_oe) else $error("drive outside write");
  a_clean: assert property (p_clean) else $error("select glitch");
  a_rlat: assert property (p_rlat) else $error("read latency");
  // Main scenarios reached
  c_write: cover property ($rose(O_DATA_OE));
  c_read: cover property ($rose(O_RVALID));
  c_b2b: cover property (O_RVALID && I_REQ && O_READY && !I_WE);
endmodule : asram_ctrl_chk

bind asram_ctrl asram_ctrl_chk u_chk (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_REQ(I_REQ),
  .I_WE(I_WE), .O_READY(O_READY), .O_RVALID(O_RVALID), .O_CSN(O_CSN),
  .O_STROBE_N(O_STROBE_N), .O_ADDR(O_ADDR), .O_DATA_OE(O_DATA_OE));

// ---- sim/asram_mem_model.sv ----
// Behavioural 1K x 4 asynchronous memory on the controller's pins.
// Assumes the bench feeds o_data back to the controller data input.
`timescale 1ns/100ps
module asram_mem_model #(
  parameter int T_ACC = 25
) (
  // Control and address from the controller
  input wire logic i_csn,
  input wire logic i_strobe_n,
  input wire logic [9:0] i_addr,
  // Controller data and its enable
  input wire logic [3:0] i_wdata,
  input wire logic i_wdata_oe,
  // Resolved data lines and contention count
  output logic [3:0] o_data,
  output int o_clash
);
  logic [3:0] mem_q [1024];
  logic [3:0] rd_q;
  logic drive;

  // Drives only when selected and not writing
  assign drive = !i_csn && i_strobe_n;
  // Addressed word inverted until access time, so early sampling is caught
  always @(i_csn or i_addr) begin
    rd_q = ~mem_q[i_addr];
    rd_q <= #(T_ACC) mem_q[i_addr];
  end
  // Either control rising ends a write and latches data
  always @(posedge i_csn or posedge i_strobe_n) begin
    if (i_csn != i_strobe_n) begin
      mem_q[i_addr] <= i_wdata;
    end
  end
  // Both parties driving at once is counted
  initial o_clash = 0;
  always @(drive or i_wdata_oe) begin
    if (drive && i_wdata_oe) begin
      o_clash++;
    end
  end
  // Released lines show the inverse of the last word
  assign o_data = i_wdata_oe ? i_wdata : drive ? rd_q : ~rd_q;
endmodule : asram_mem_model

// ---- sim/tb_top.sv ----
// Self-checking bench: controller against the behavioural memory.
// Assumes the checker binds itself into the controller.
`timescale 1ns/100ps
module tb_top;
  logic I_MCLK = 1'b0;
  logic I_RESET = 1'b1;
  logic I_REQ = 1'b0;
  logic I_WE = 1'b0;
  logic [9:0] I_ADDR = 10'h000;
  logic [3:0] I_WDATA = 4'h0;
  logic O_READY, O_RVALID, O_CSN, O_STROBE_N, O_DATA_OE;
  logic [9:0] O_ADDR;
  logic [3:0] O_RDATA, O_DATA, I_DATA;
  int fails = 0;
  int check_count = 0;
  int clash;

  // Controller clock, 5 ns period
  always #2.5 I_MCLK = ~I_MCLK;

  asram_ctrl uut (.I_MCLK(I_MCLK), .I_RESET(I_RESET), .I_REQ(I_REQ), .I_WE(I_WE),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .O_READY(O_READY), .O_RVALID(O_RVALID),
    .O_RDATA(O_RDATA), .O_CSN(O_CSN), .O_STROBE_N(O_STROBE_N), .O_ADDR(O_ADDR),
    .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE), .I_DATA(I_DATA));
  asram_mem_model mem (.i_csn(O_CSN), .i_strobe_n(O_STROBE_N), .i_addr(O_ADDR),
    .i_wdata(O_DATA), .i_wdata_oe(O_DATA_OE), .o_data(I_DATA), .o_clash(clash));

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : check

  // Request held from a falling edge until a ready edge takes it
  task automatic req(input logic we, input logic [9:0] a, input logic [3:0] d);
    I_REQ = 1'b1;
    I_WE = we;
    I_ADDR = a;
    I_WDATA = d;
    while (O_READY !== 1'b1) @(negedge I_MCLK);
    @(negedge I_MCLK);
    I_REQ = 1'b0;
  endtask : req

  task automatic wait_rdy();
    for (int n = 0; n < 30 && O_READY !== 1'b1; n++) @(negedge I_MCLK);
  endtask : wait_rdy

  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    req(1'b1, a, d);
    wait_rdy();
  endtask : wr

  task automatic wait_rd(input logic [3:0] exp);
    for (int n = 0; n < 30 && O_RVALID !== 1'b1; n++) @(negedge I_MCLK);
    check(O_RVALID === 1'b1 && O_RDATA === exp, "read data");
  endtask : wait_rd

  task automatic rd(input logic [9:0] a, input logic [3:0] exp);
    req(1'b0, a, 4'h0);
    wait_rd(exp);
  endtask : rd

  // Each address bit alone, then the top word
  task automatic t_walk();
    for (int i = 0; i < 10; i++) wr(10'h001 << i, 4'(i + 1));
    wr(10'h3FF, 4'hA);
    for (int i = 0; i < 10; i++) rd(10'h001 << i, 4'(i + 1));
    rd(10'h3FF, 4'hA);
  endtask : t_walk

  // Second read taken on the valid cycle keeps select low
  task automatic t_b2b();
    rd(10'h3FF, 4'hA);
    req(1'b0, 10'h001, 4'h0);
    check(O_CSN === 1'b0, "select kept low");
    wait_rd(4'h1);
    wait_rdy();
  endtask : t_b2b

  // Long deselect before a read
  task automatic t_idle();
    repeat (50) @(negedge I_MCLK);
    check(O_CSN === 1'b1 && O_DATA_OE === 1'b0, "standby pins");
    rd(10'h200, 4'hA);
  endtask : t_idle

  // A request while busy must be ignored
  task automatic t_refuse();
    req(1'b1, 10'h155, 4'h3);
    @(negedge I_MCLK);
    I_REQ = 1'b1;
    I_WDATA = 4'hC;
    repeat (3) @(negedge I_MCLK);
    I_REQ = 1'b0;
    wait_rdy();
    rd(10'h155, 4'h3);
  endtask : t_refuse

  task automatic finish_test();
    $display("Checks: %0d, mismatches: %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (4) @(negedge I_MCLK);
    I_RESET = 1'b0;
    @(negedge I_MCLK);
    check(O_CSN === 1'b1 && O_STROBE_N === 1'b1 && O_DATA_OE === 1'b0, "reset pins");
    t_walk();
    t_b2b();
    t_idle();
    t_refuse();
    check(clash === 0, "bus contention");
    finish_test();
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #20000;
    fails++;
    $display("CHECK FAILED at %0t: timeout", $time);
    finish_test();
  end
endmodule : tb_top
